// File: rtl/socl_defines.vh
`ifndef SOCL_DEFINES_VH
`define SOCL_DEFINES_VH
`define SOCL_WORD_W 39
`define SOCL_OPT_LO 25
`define SOCL_OPT_W 14
`define SOCL_TONE_BIT 38
`define SOCL_EOL_BIT 37
`define SOCL_LBS_BIT 36
`define SOCL_SIL_BIT 35
`define SOCL_DRIFT_BIT 34
`define SOCL_LB_HI 33
`define SOCL_LB_LO 31
`define SOCL_IRC_HI 30
`define SOCL_IRC_LO 29
`define SOCL_IT_HI 28
`define SOCL_IT_LO 27
`define SOCL_GAIN_HI 26
`define SOCL_GAIN_LO 25
`define SOCL_NL_LO 20
`define SOCL_HYL_LO 15
`define SOCL_SIL_LO 10
`define SOCL_CTL_LO 5
`define SOCL_BASE_LO 0
`define SOCL_MODE_W 4
`define SOCL_MODE_OPT 4'h1
`define SOCL_MODE_FULL 4'h6
`define SOCL_MODE_MAX 4'hb
`define SOCL_STORE_MS 10
`define SOCL_CLK_KHZ 200000
`define SOCL_STORE_CYC (`SOCL_STORE_MS * `SOCL_CLK_KHZ)
`endif

// File: rtl/socl_loader.v
`timescale 1ns/1ps
`include "socl_defines.vh"

module socl_loader #(
  parameter STORE_CYC = `SOCL_STORE_CYC
)(
  // System
  input wire clk,
  input wire sys_rst,
  // Programming pins
  input wire mode_hold_pin,
  input wire data_pin,
  input wire data_boost_pin,
  input wire shift_clk_pin,
  input wire store_pin,
  // Readback
  output reg horn_drive_pin,
  output reg [3:0] test_mode,
  output reg store_busy,
  // Stored word
  output reg [`SOCL_WORD_W-1:0] config_calibration_word,
  output wire horn_pattern_select,
  output wire end_of_life_enable,
  output wire low_battery_silence_enable,
  output wire silence_option,
  output wire drift_enable,
  output wire [2:0] battery_trip_select,
  output wire [1:0] emitter_current_select,
  output wire [1:0] integration_time_select,
  output wire [1:0] amplifier_gain_select,
  output wire [4:0] normal_alarm_limit,
  output wire [4:0] hysteresis_limit,
  output wire [4:0] silence_limit,
  output wire [4:0] chamber_check_limit,
  output wire [4:0] drift_baseline
);
  localparam ST_IDLE = 2'h0;
  localparam ST_HIGH = 2'h1;
  localparam CNT_W = 32;

  // Synchroniser stages and the edge-detect copy.
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg [4:0] d_reg;

  // Load registers and the strobe timer.
  reg [`SOCL_WORD_W-1:0] shift_reg;
  reg [`SOCL_OPT_W-1:0] opt_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [1:0] st_reg;

  // Decoded pin events.
  wire hold;
  wire dat;
  wire boost_rise;
  wire sclk_rise;
  wire store_hi;
  wire store_fall;
  wire opt_mode;
  wire full_mode;
  wire commit_now;

  // One five-bit limit field of the stored word; all five limit fields share this.
  function [4:0] limit_field;
    input [`SOCL_WORD_W-1:0] word;
    input integer lo;
    begin
      limit_field = word[lo +: 5];
    end
  endfunction

  // True when the current mode equals the given code.
  function mode_is;
    input [3:0] mode;
    input [3:0] code;
    begin
      mode_is = (mode == code);
    end
  endfunction

  assign hold = s2_reg[0];
  assign dat = s2_reg[1];
  assign boost_rise = s2_reg[2] & ~d_reg[2];
  assign sclk_rise = s2_reg[3] & ~d_reg[3];
  assign store_hi = s2_reg[4];
  assign store_fall = ~s2_reg[4] & d_reg[4];
  assign opt_mode = mode_is(test_mode, `SOCL_MODE_OPT);
  assign full_mode = mode_is(test_mode, `SOCL_MODE_FULL);

  // Every pin crosses two flip-flops before use.
  always @(posedge clk)
  begin
    s1_reg <= {store_pin, shift_clk_pin, data_boost_pin, data_pin, mode_hold_pin};
    s2_reg <= s1_reg;
    d_reg <= s2_reg;
  end

  // Leaving programming drops the mode but keeps the stored word.
  always @(posedge clk)
  begin
    if (sys_rst)
      test_mode <= 4'h0;
    else if (!hold)
      test_mode <= 4'h0;
    else if (boost_rise && test_mode != `SOCL_MODE_MAX)
      test_mode <= test_mode + 4'h1;
  end

  // Option bits enter at the top, so the last of fourteen settles at bit 38.
  always @(posedge clk)
  begin
    if (sys_rst)
      opt_reg <= {`SOCL_OPT_W{1'b0}};
    else if (hold && sclk_rise && opt_mode)
      opt_reg <= {dat, opt_reg[`SOCL_OPT_W-1:1]};
  end

  // The full word enters lowest bit first, so bit 0 ends at the output end.
  always @(posedge clk)
  begin
    if (sys_rst)
      shift_reg <= {`SOCL_WORD_W{1'b0}};
    else if (hold && sclk_rise && full_mode)
      shift_reg <= {dat, shift_reg[`SOCL_WORD_W-1:1]};
  end

  // The bit now at the output end is what the next shift clock pushes out.
  always @(posedge clk)
  begin
    if (sys_rst)
      horn_drive_pin <= 1'b0;
    else if (hold && full_mode)
      horn_drive_pin <= shift_reg[0];
    else
      horn_drive_pin <= 1'b0;
  end

  // Times the strobe high phase; the timer saturates so a long strobe cannot wrap.
  always @(posedge clk)
  begin
    if (sys_rst || !hold)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      store_busy <= 1'b0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
        begin
          cnt_reg <= {CNT_W{1'b0}};
          store_busy <= 1'b0;
          if (store_hi)
          begin
            st_reg <= ST_HIGH;
            store_busy <= 1'b1;
          end
        end
        ST_HIGH:
        begin
          if (cnt_reg < STORE_CYC)
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          if (store_fall)
          begin
            st_reg <= ST_IDLE;
            store_busy <= 1'b0;
          end
        end
        default:
        begin
          st_reg <= ST_IDLE;
          store_busy <= 1'b0;
        end
      endcase
    end
  end

  // A strobe shorter than the minimum is ignored, so a glitch cannot commit.
  assign commit_now = hold && (st_reg == ST_HIGH) && store_fall && (cnt_reg >= STORE_CYC - 1);

  always @(posedge clk)
  begin
    if (sys_rst)
      config_calibration_word <= {`SOCL_WORD_W{1'b0}};
    else if (commit_now && full_mode)
      config_calibration_word <= shift_reg;
    else if (commit_now && opt_mode)
      config_calibration_word[`SOCL_WORD_W-1:`SOCL_OPT_LO] <= opt_reg;
  end

  // Field decode of the stored word.
  assign horn_pattern_select = config_calibration_word[`SOCL_TONE_BIT];
  assign end_of_life_enable = config_calibration_word[`SOCL_EOL_BIT];
  assign low_battery_silence_enable = config_calibration_word[`SOCL_LBS_BIT];
  assign silence_option = config_calibration_word[`SOCL_SIL_BIT];
  assign drift_enable = config_calibration_word[`SOCL_DRIFT_BIT];
  assign battery_trip_select = config_calibration_word[`SOCL_LB_HI:`SOCL_LB_LO];
  assign emitter_current_select = config_calibration_word[`SOCL_IRC_HI:`SOCL_IRC_LO];
  assign integration_time_select = config_calibration_word[`SOCL_IT_HI:`SOCL_IT_LO];
  assign amplifier_gain_select = config_calibration_word[`SOCL_GAIN_HI:`SOCL_GAIN_LO];

  // The limit fields carry no sign and span the whole five-bit range.
  assign normal_alarm_limit = limit_field(config_calibration_word, `SOCL_NL_LO);
  assign hysteresis_limit = limit_field(config_calibration_word, `SOCL_HYL_LO);
  assign silence_limit = limit_field(config_calibration_word, `SOCL_SIL_LO);
  assign chamber_check_limit = limit_field(config_calibration_word, `SOCL_CTL_LO);
  assign drift_baseline = limit_field(config_calibration_word, `SOCL_BASE_LO);
endmodule // socl_loader

// File: dv/socl_chk.sv
`timescale 1ns/1ps
module socl_chk #(parameter STORE_CYC = 20) (
  // Watched ports
  input logic clk, sys_rst, mode_hold_pin, horn_drive_pin, store_busy,
  input logic [3:0] test_mode,
  input logic [38:0] config_calibration_word,
  input logic [2:0] battery_trip_select,
  input logic [1:0] amplifier_gain_select,
  input logic [4:0] normal_alarm_limit, hysteresis_limit, silence_limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold_off; !mode_hold_pin [*2]; endsequence
  sequence s_commit; $changed(config_calibration_word); endsequence
  a_hold_exit: assert property (s_hold_off |-> ##[0:4] test_mode == 4'h0) else $error("mode kept");
  a_mode_top: assert property (test_mode <= 4'hb) else $error("mode above top");
  a_mode_step: assert property ($changed(test_mode) |->
    test_mode == $past(test_mode) + 4'h1 || test_mode == 4'h0) else $error("mode skipped");
  a_horn_quiet: assert property (test_mode != 4'h6 && $past(test_mode) != 4'h6 |-> !horn_drive_pin)
    else $error("horn driven");
  a_commit_only: assert property (s_commit |-> $past(store_busy) && test_mode inside {4'h1, 4'h6})
    else $error("word changed");
  a_opt_keep: assert property (s_commit ##0 test_mode == 4'h1 |->
    config_calibration_word[24:0] == $past(config_calibration_word[24:0])) else $error("low bits hit");
  a_trip_gain: assert property (battery_trip_select == config_calibration_word[33:31] &&
    amplifier_gain_select == config_calibration_word[26:25]) else $error("option slice");
  a_limit_slices: assert property (normal_alarm_limit == config_calibration_word[24:20] &&
    hysteresis_limit == config_calibration_word[19:15] && silence_limit == config_calibration_word[14:10])
    else $error("limit slice");
endmodule // socl_chk
bind socl_loader socl_chk #(.STORE_CYC(STORE_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .mode_hold_pin(mode_hold_pin), .horn_drive_pin(horn_drive_pin), .store_busy(store_busy),
  .test_mode(test_mode), .config_calibration_word(config_calibration_word),
  .battery_trip_select(battery_trip_select), .amplifier_gain_select(amplifier_gain_select),
  .normal_alarm_limit(normal_alarm_limit), .hysteresis_limit(hysteresis_limit), .silence_limit(silence_limit));

// File: dv/socl_prog.sv
`timescale 1ns/1ps
module socl_prog (
  // Pins toward the loader
  input logic clk,
  output logic hold, data, boost, sclk, store
);
  initial {hold, data, boost, sclk, store} = 5'h0;
  task automatic step(input int n);
    repeat (n)
    begin
      #32 boost = 1;
      #32 boost = 0;
    end
  endtask
  // Lowest bit first; the released line flips so a stale bit cannot pass.
  task automatic shift(input logic [38:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      data = w[i];
      #32 sclk = 1;
      #32 sclk = 0;
    end
    data = ~data;
  endtask
  task automatic strobe(input int cyc);
    @(posedge clk) #1 store = 1;
    repeat (cyc) @(posedge clk);
    #1 store = 0;
  endtask
endmodule // socl_prog

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int STORE = 20;
  localparam logic [38:0] W = 39'h4b7d29c6a5;
  localparam logic [13:0] V = 14'h2d96;
  logic clk = 0, sys_rst = 1, horn, hold, data, boost, sclk, store;
  logic [3:0] mode;
  logic [38:0] word;
  logic busy;
  wire [38:0] fields;
  int num_errors = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  socl_prog prog (.clk(clk), .hold(hold), .data(data), .boost(boost), .sclk(sclk), .store(store));
  socl_loader #(.STORE_CYC(STORE)) dut (.clk(clk), .sys_rst(sys_rst), .mode_hold_pin(hold), .data_pin(data),
    .data_boost_pin(boost), .shift_clk_pin(sclk), .store_pin(store), .horn_drive_pin(horn), .test_mode(mode),
    .store_busy(busy), .config_calibration_word(word), .horn_pattern_select(fields[38]),
    .end_of_life_enable(fields[37]), .low_battery_silence_enable(fields[36]), .silence_option(fields[35]),
    .drift_enable(fields[34]), .battery_trip_select(fields[33:31]), .emitter_current_select(fields[30:29]),
    .integration_time_select(fields[28:27]), .amplifier_gain_select(fields[26:25]),
    .normal_alarm_limit(fields[24:20]), .hysteresis_limit(fields[19:15]), .silence_limit(fields[14:10]),
    .chamber_check_limit(fields[9:5]), .drift_baseline(fields[4:0]));
  task automatic chk(input string name, input logic [38:0] seen, input logic [38:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic commit(input int cyc);
    fork
      prog.strobe(cyc);
      begin
        repeat (8) @(posedge clk);
        chk("busy", busy, 39'd1);
      end
    join
    repeat (6) @(posedge clk);
    chk("idle", busy, 39'd0);
  endtask
  task automatic full_load;
    prog.hold = 1;
    prog.step(6);
    repeat (6) @(posedge clk);
    chk("mode", mode, 39'd6);
    prog.shift(W, 39);
    repeat (6) @(posedge clk);
    chk("horn", horn, W[0]);
    commit(STORE + 4);
    chk("word", word, W);
    chk("trip", fields[33:31], W[33:31]);
    chk("limit", fields[24:20], W[24:20]);
    chk("fields", fields, W);
  endtask
  task automatic opt_load;
    #1 sys_rst = 1;
    repeat (3) @(posedge clk);
    #1 sys_rst = 0;
    repeat (2) @(posedge clk);
    chk("cleared", word, 39'h0);
    prog.step(13);
    repeat (6) @(posedge clk);
    chk("top", mode, 39'd11);
    #1 prog.hold = 0;
    repeat (6) @(posedge clk);
    chk("exit", mode, 39'd0);
    #1 prog.hold = 1;
    prog.step(1);
    prog.shift({25'h0, V}, 14);
    commit(STORE - 4);
    chk("short", word, 39'h0);
    commit(STORE + 4);
    chk("opt", word, {V, 25'h0});
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 0;
    full_load();
    opt_load();
    summarize();
  end
endmodule // tb_top
